// *** verilog/lsd_pkg.sv ***
// shared constants and types of the led sink control block
`default_nettype none
package lsd_pkg;
   localparam int         NCH            = 8;
   localparam int         SYNC_W         = 4 + 5 * NCH + 1;
   localparam logic [7:0] CFG_RESET      = 8'hFF;
   localparam logic [7:0] LATCH_RESET    = 8'h00;
   localparam logic [2:0] EN_HIST_RESET  = 3'h7;
   localparam logic [2:0] EN_PATTERN     = 3'h5;
   localparam logic [1:0] SW_FIRST       = 2'h2;
   localparam logic [1:0] SW_LAST        = 2'h1;
   localparam logic [1:0] SW_IDLE        = 2'h0;
   localparam logic [1:0] LOW_CAPTURE    = 2'h2;
   localparam logic [1:0] LOW_MAX        = 2'h3;
   localparam int         CFG_CM_BIT     = 0;
   localparam int         CFG_BAND_BIT   = 1;
   localparam int         CFG_MANT_LSB   = 2;
   localparam int         ADDR_W         = 8;
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_LATCH     = 8'h08;
   localparam logic [7:0] ADDR_ERROR     = 8'h0C;
   localparam int         CTRL_SHORT_BIT = 0;
   localparam logic       CTRL_RESET     = 1'b1;
   localparam int         STAT_MODE_BIT  = 0;
   localparam int         STAT_SW_BIT    = 1;
   localparam int         STAT_DET_BIT   = 2;
   localparam int         LATCH_CFG_LSB  = 8;
   localparam int         ERR_SHORT_LSB  = 8;
   localparam int         ERR_HOT_LSB    = 16;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   typedef enum logic [0:0] {
      LSD_NORMAL  = 1'b0,
      LSD_SPECIAL = 1'b1
   } lsd_mode_t;

   typedef struct packed {
      logic       sclk;
      logic       sdata;
      logic       latch;
      logic       enable_n;
      logic [7:0] open_ok;
      logic [7:0] short_trip;
      logic [7:0] short_release;
      logic [7:0] chan_hot;
      logic [7:0] spare;
      logic       global_hot;
   } lsd_pins_t;
endpackage
`default_nettype wire

// *** verilog/lsd_top.sv ***
// serial mode, latch and error readout logic of the led sink driver
// How it works
// - enable samples high-low-high start a two-clock mode switching phase
// - fourth edge samples latch line: high gives special, low normal
// - latch line latches nothing from third to fifth edge of switching
// - short enable pulse still drives sinks; shifting continues unaffected
// - after reset the block is in normal mode
// - normal: shift serial data, latch to output latch, low enable drives sinks
// - special with enable high shifts data exactly as normal
// - special with enable low drives sinks and starts error detection
// - after second low sample the shift source becomes error status
// - third and later low samples capture status; serial input ignored
// - enable high restores serial source, disables sinks, status shifts out
// - special latch strobe loads configuration latch with normal timing
// - configuration latch holds until reset or new special latch
// - open status is 0 when off or current low, 1 when fine
// - short variant: trip gives 0, back to 1 below release, off gives 0
// - global overheat turns all off, stores 0 for every channel
// - channel overheat turns that channel off, stores 0 for it
// - stored overheat bits clear when returning to normal mode; short bits hold until release
// - config shifts msb first; bit0 multiplier, bit1 band, 7:2 mantissa
// - configuration latch resets to all ones
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module lsd_top (
   input  wire logic        SYS_CLK,
   input  wire logic        SYS_RST,
   input  wire logic        SCLK,
   input  wire logic        SERIAL_IN,
   input  wire logic        LATCH_STROBE_MODE_SELECT,
   input  wire logic        ENABLE_N_DETECT_STROBE,
   input  wire logic [7:0]  OPEN_OK,
   input  wire logic [7:0]  SHORT_TRIP,
   input  wire logic [7:0]  SHORT_RELEASE,
   input  wire logic [7:0]  CHAN_HOT,
   input  wire logic        GLOBAL_HOT,
   output logic             SERIAL_OUT,
   output logic [7:0]       SINK_OUTPUT,
   output logic             CURRENT_MULTIPLIER_BIT,
   output logic             GAIN_BAND_BIT,
   output logic [5:0]       GAIN_MANTISSA,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic [2:0]  S_AXI_AWPROT,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   output logic [1:0]       S_AXI_BRESP,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic [2:0]  S_AXI_ARPROT,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP
);
   // pin synchroniser
   lsd_pkg::lsd_pins_t sync1;
   lsd_pkg::lsd_pins_t pins;
   logic               sclk_prev;
   logic               rise;

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         sync1     <= '0;
         pins      <= '0;
         sclk_prev <= 1'b0;
      end else begin
         sync1     <= {SCLK, SERIAL_IN, LATCH_STROBE_MODE_SELECT,
                       ENABLE_N_DETECT_STROBE, OPEN_OK, SHORT_TRIP,
                       SHORT_RELEASE, CHAN_HOT, 8'h00, GLOBAL_HOT};
         pins      <= sync1;
         sclk_prev <= pins.sclk;
      end
   end

   assign rise = pins.sclk & ~sclk_prev;

   // serial clock domain state, advanced on each sampled rising edge
   lsd_pkg::lsd_mode_t mode;
   lsd_pkg::lsd_mode_t next_mode;
   logic [2:0]         en_hist;
   logic [2:0]         next_en_hist;
   logic [1:0]         sw_cnt;
   logic [1:0]         next_sw_cnt;
   logic [1:0]         low_cnt;
   logic [1:0]         next_low_cnt;
   logic [7:0]         shreg;
   logic [7:0]         next_shreg;
   logic [7:0]         out_latch;
   logic [7:0]         next_out_latch;
   logic [7:0]         cfg;
   logic [7:0]         next_cfg;
   logic [7:0]         err_code;
   logic               pattern;
   logic               latch_block;
   logic               capture;
   logic               to_normal;

   always_comb begin
      next_mode      = mode;
      next_en_hist   = en_hist;
      next_sw_cnt    = sw_cnt;
      next_low_cnt   = low_cnt;
      next_shreg     = shreg;
      next_out_latch = out_latch;
      next_cfg       = cfg;
      pattern        = ({en_hist[1:0], pins.enable_n} == lsd_pkg::EN_PATTERN);
      latch_block    = pattern | (sw_cnt != lsd_pkg::SW_IDLE);
      capture        = (mode == lsd_pkg::LSD_SPECIAL) & ~pins.enable_n
                       & (low_cnt >= lsd_pkg::LOW_CAPTURE);
      to_normal      = rise & (sw_cnt == lsd_pkg::SW_FIRST) & ~pins.latch;
      if (rise) begin
         next_en_hist = {en_hist[1:0], pins.enable_n};
         if (pattern) begin
            next_sw_cnt = lsd_pkg::SW_FIRST;
         end else if (sw_cnt != lsd_pkg::SW_IDLE) begin
            next_sw_cnt = sw_cnt - 2'h1;
         end
         if (sw_cnt == lsd_pkg::SW_FIRST) begin
            next_mode = pins.latch ? lsd_pkg::LSD_SPECIAL
                                   : lsd_pkg::LSD_NORMAL;
         end
         if (pins.enable_n) begin
            next_low_cnt = 2'h0;
         end else if (low_cnt != lsd_pkg::LOW_MAX) begin
            next_low_cnt = low_cnt + 2'h1;
         end
         // status bit n lands on channel n's position
         if (capture) begin
            next_shreg = err_code;
         end else begin
            next_shreg = {shreg[6:0], pins.sdata};
         end
         if (pins.latch && !latch_block) begin
            if (mode == lsd_pkg::LSD_SPECIAL) begin
               next_cfg = shreg;
            end else begin
               next_out_latch = shreg;
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         mode       <= lsd_pkg::LSD_NORMAL;
         en_hist    <= lsd_pkg::EN_HIST_RESET;
         sw_cnt     <= lsd_pkg::SW_IDLE;
         low_cnt    <= 2'h0;
         shreg      <= 8'h00;
         out_latch  <= lsd_pkg::LATCH_RESET;
         cfg        <= lsd_pkg::CFG_RESET;
         SERIAL_OUT <= 1'b0;
      end else begin
         mode       <= next_mode;
         en_hist    <= next_en_hist;
         sw_cnt     <= next_sw_cnt;
         low_cnt    <= next_low_cnt;
         shreg      <= next_shreg;
         out_latch  <= next_out_latch;
         cfg        <= next_cfg;
         SERIAL_OUT <= next_shreg[7];
      end
   end

   assign CURRENT_MULTIPLIER_BIT = cfg[lsd_pkg::CFG_CM_BIT];
   assign GAIN_BAND_BIT          = cfg[lsd_pkg::CFG_BAND_BIT];
   assign GAIN_MANTISSA          = cfg[7:lsd_pkg::CFG_MANT_LSB];

   // sinks and error detection
   logic       short_en;
   logic [7:0] short_flag;
   logic [7:0] next_short_flag;
   logic [7:0] hot_flag;
   logic [7:0] next_hot_flag;
   logic [7:0] next_sink;
   logic [7:0] hot_set;

   always_comb begin
      // a hot channel stays off only while hot; latch bit restarts it
      next_sink = out_latch & {8{~pins.enable_n}} & {8{~pins.global_hot}}
                  & ~pins.chan_hot;
      hot_set   = {8{pins.global_hot}}
                  | (pins.chan_hot & SINK_OUTPUT);
      // a new event wins over the clear on return to normal
      next_hot_flag = (to_normal ? 8'h00 : hot_flag) | hot_set;
      if (short_en) begin
         next_short_flag = (SINK_OUTPUT & pins.short_trip)
                           | (short_flag & ~pins.short_release);
      end else begin
         next_short_flag = 8'h00;
      end
      err_code = SINK_OUTPUT & pins.open_ok & ~short_flag
                 & ~hot_flag;
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         SINK_OUTPUT <= 8'h00;
         short_flag  <= 8'h00;
         hot_flag    <= 8'h00;
      end else begin
         SINK_OUTPUT <= next_sink;
         short_flag  <= next_short_flag;
         hot_flag    <= next_hot_flag;
      end
   end

   // axi4-lite register slave
   logic       aw_full;
   logic       next_aw_full;
   logic [7:0] aw_addr;
   logic [7:0] next_aw_addr;
   logic       w_full;
   logic       next_w_full;
   logic [7:0] w_data;
   logic [7:0] next_w_data;
   logic       w_strb0;
   logic       next_w_strb0;
   logic       next_bvalid;
   logic [1:0] next_bresp;
   logic       next_short_en;
   logic       next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic       wr_go;

   always_comb begin
      next_aw_full  = aw_full;
      next_aw_addr  = aw_addr;
      next_w_full   = w_full;
      next_w_data   = w_data;
      next_w_strb0  = w_strb0;
      next_bvalid   = S_AXI_BVALID & ~S_AXI_BREADY;
      next_bresp    = S_AXI_BRESP;
      next_short_en = short_en;
      next_rvalid   = S_AXI_RVALID & ~S_AXI_RREADY;
      next_rdata    = S_AXI_RDATA;
      next_rresp    = S_AXI_RRESP;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         next_aw_full = 1'b1;
         next_aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         next_w_full  = 1'b1;
         next_w_data  = S_AXI_WDATA[7:0];
         next_w_strb0 = S_AXI_WSTRB[0];
      end
      wr_go = aw_full & w_full & ~S_AXI_BVALID;
      if (wr_go) begin
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = lsd_pkg::RESP_OKAY;
         unique case (aw_addr)
            lsd_pkg::ADDR_CTRL: begin
               if (w_strb0) begin
                  next_short_en = w_data[lsd_pkg::CTRL_SHORT_BIT];
               end
            end
            lsd_pkg::ADDR_STATUS, lsd_pkg::ADDR_LATCH,
            lsd_pkg::ADDR_ERROR: begin
               next_bresp = lsd_pkg::RESP_OKAY;
            end
            default: next_bresp = lsd_pkg::RESP_SLVERR;
         endcase
      end
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         next_rvalid = 1'b1;
         next_rresp  = lsd_pkg::RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         unique case (S_AXI_ARADDR)
            lsd_pkg::ADDR_CTRL:
               next_rdata[lsd_pkg::CTRL_SHORT_BIT] = short_en;
            lsd_pkg::ADDR_STATUS: begin
               next_rdata[lsd_pkg::STAT_MODE_BIT] = mode;
               next_rdata[lsd_pkg::STAT_SW_BIT]   = (sw_cnt != lsd_pkg::SW_IDLE);
               next_rdata[lsd_pkg::STAT_DET_BIT]  = capture;
            end
            lsd_pkg::ADDR_LATCH: begin
               next_rdata[7:0] = out_latch;
               next_rdata[lsd_pkg::LATCH_CFG_LSB +: 8] = cfg;
            end
            lsd_pkg::ADDR_ERROR: begin
               next_rdata[7:0] = err_code;
               next_rdata[lsd_pkg::ERR_SHORT_LSB +: 8] = short_flag;
               next_rdata[lsd_pkg::ERR_HOT_LSB +: 8]   = hot_flag;
            end
            default: next_rresp = lsd_pkg::RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         aw_full       <= 1'b0;
         aw_addr       <= 8'h00;
         w_full        <= 1'b0;
         w_data        <= 8'h00;
         w_strb0       <= 1'b0;
         short_en      <= lsd_pkg::CTRL_RESET;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= lsd_pkg::RESP_OKAY;
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0000_0000;
         S_AXI_RRESP   <= lsd_pkg::RESP_OKAY;
      end else begin
         aw_full       <= next_aw_full;
         aw_addr       <= next_aw_addr;
         w_full        <= next_w_full;
         w_data        <= next_w_data;
         w_strb0       <= next_w_strb0;
         short_en      <= next_short_en;
         S_AXI_AWREADY <= ~next_aw_full & ~(S_AXI_AWVALID & S_AXI_AWREADY);
         S_AXI_WREADY  <= ~next_w_full & ~(S_AXI_WVALID & S_AXI_WREADY);
         S_AXI_BVALID  <= next_bvalid;
         S_AXI_BRESP   <= next_bresp;
         S_AXI_ARREADY <= ~next_rvalid & ~(S_AXI_ARVALID & S_AXI_ARREADY);
         S_AXI_RVALID  <= next_rvalid;
         S_AXI_RDATA   <= next_rdata;
         S_AXI_RRESP   <= next_rresp;
      end
   end

   // checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   chk_switch_start: assert property (rise && pattern |=>
      sw_cnt == lsd_pkg::SW_FIRST)
      else $error("switching phase not entered");
   chk_switch_len: assert property (rise
      && sw_cnt == lsd_pkg::SW_FIRST |=> sw_cnt == lsd_pkg::SW_LAST)
      else $error("switching phase length wrong");
   chk_mode_edge: assert property ($changed(mode) |->
      $past(rise) && $past(sw_cnt) == lsd_pkg::SW_FIRST
      && mode == $past(pins.latch))
      else $error("mode changed outside the fourth edge");
   chk_latch_blocked: assert property (rise && latch_block |=>
      $stable(out_latch) && $stable(cfg))
      else $error("latch taken during switching");
   chk_normal_latch: assert property (rise && pins.latch
      && !latch_block && mode == lsd_pkg::LSD_NORMAL |=>
      out_latch == $past(shreg) && $stable(cfg))
      else $error("normal latch did not load output latch");
   chk_config_latch: assert property (rise && pins.latch
      && !latch_block && mode == lsd_pkg::LSD_SPECIAL |=>
      cfg == $past(shreg) && $stable(out_latch))
      else $error("special latch did not load config");
   chk_cfg_hold: assert property (!rise |=> $stable(cfg))
      else $error("config changed without a clock edge");
   chk_status_capture: assert property (rise && capture |=>
      shreg == $past(err_code))
      else $error("status not captured");
   chk_serial_shift: assert property (rise && !capture |=>
      shreg == {$past(shreg[6:0]), $past(pins.sdata)} ##1
      SERIAL_OUT == $past(shreg[7]))
      else $error("serial shift broken");
   chk_sink_disable: assert property (pins.enable_n |=>
      SINK_OUTPUT == 8'h00)
      else $error("sinks on while enable high");
   chk_global_hot: assert property (pins.global_hot |=>
      hot_flag == 8'hFF && SINK_OUTPUT == 8'h00 ##1 err_code == 8'h00)
      else $error("global overheat not stored");
   chk_clear_normal: assert property (to_normal
      && hot_set == 8'h00 |=> hot_flag == 8'h00)
      else $error("error bits not cleared on normal");

   cov_enter_special: cover property (rise && sw_cnt == lsd_pkg::SW_FIRST
      && pins.latch);
   cov_capture: cover property (rise && capture);
   cov_cfg_write: cover property (rise && pins.latch && !latch_block
      && mode == lsd_pkg::LSD_SPECIAL);
   cov_axi_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule // lsd_top
`default_nettype wire

// *** verification/lsd_ctrl_model.sv ***
// controller model driving the serial pins of the led sink block
`timescale 1ns/1ps
`default_nettype none
module lsd_ctrl_model (
   input  wire logic sys_clk,
   input  wire logic serial_out,
   output var logic  sclk,
   output var logic  serial_in,
   output var logic  latch_strobe_mode_select,
   output var logic  enable_n_detect_strobe
);
   initial begin
      sclk = 1'b0;
      serial_in = 1'b0;
      latch_strobe_mode_select = 1'b0;
      enable_n_detect_strobe = 1'b1;
   end

   // one serial clock: levels set, then edge; so is the output before it
   task automatic tick(input logic d, input logic l, input logic e,
                       output logic s);
      @(posedge sys_clk);
      serial_in <= d;
      latch_strobe_mode_select <= l;
      enable_n_detect_strobe <= e;
      repeat (5) @(posedge sys_clk);
      s = serial_out;
      sclk <= 1'b1;
      repeat (6) @(posedge sys_clk);
      sclk <= 1'b0;
   endtask

   // shift a byte msb first, optional latch edge after it
   task automatic byte_io(input logic [7:0] b, input logic e,
                          input logic l, output logic [7:0] s);
      logic t;
      for (int i = 7; i >= 0; i--) begin
         tick(b[i], 1'b0, e, t);
         s[i] = t;
      end
      if (l) begin
         tick(1'b0, 1'b1, e, t);
      end
   endtask

   // one clock low pulse, then mode level on the fourth edge
   task automatic sw_mode(input logic m);
      logic t;
      tick(1'b0, 1'b0, 1'b1, t);
      tick(1'b0, 1'b0, 1'b0, t);
      tick(1'b0, 1'b1, 1'b1, t);
      tick(1'b0, m, 1'b1, t);
      tick(1'b0, 1'b1, 1'b1, t);
   endtask

   // hold enable low over n clocks, long enough for valid status
   task automatic low(input int n);
      logic t;
      for (int i = 0; i < n; i++) begin
         tick(1'b0, 1'b0, 1'b0, t);
      end
   endtask
endmodule // lsd_ctrl_model
`default_nettype wire

// *** verification/led_sink_mode_and_error_readout_bench.sv ***
// self-checking bench of the led sink control block
`timescale 1ns/1ps
`default_nettype none
module led_sink_mode_and_error_readout_bench;
   typedef struct packed {
      logic [31:0] d;
      logic [1:0]  r;
   } lsd_rd_t;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        sclk, sdat, lat, en_n, so;
   logic [7:0]  ook = 8'h00, trip = 8'h00, rel = 8'h00, hot = 8'h00;
   logic        ghot = 1'b0;
   logic [7:0]  sink, awa = 8'h00, ara = 8'h00;
   logic        cm, band, awv = 1'b0, wv = 1'b0, bry = 1'b0;
   logic        arv = 1'b0, rry = 1'b0, awr, wr_rdy, bv, arr, rv;
   logic [5:0]  mant;
   logic [31:0] wd = 32'h0000_0000, rdata;
   logic [1:0]  bresp, rresp;
   logic [7:0]  b, o, cfg, r, s, sm, hm;
   logic [3:0]  stb = 4'hF;
   logic [2:0]  awp = 3'h0, arp = 3'h0;
   lsd_rd_t     q[$];
   lsd_rd_t     e;
   int          error_cnt = 0;
   int          checked = 0;

   always #2.5 clk = ~clk;

   lsd_ctrl_model ctl (.sys_clk(clk), .serial_out(so), .sclk(sclk),
      .serial_in(sdat), .latch_strobe_mode_select(lat),
      .enable_n_detect_strobe(en_n));

   lsd_top DUT (.SYS_CLK(clk), .SYS_RST(rst), .SCLK(sclk),
      .SERIAL_IN(sdat), .LATCH_STROBE_MODE_SELECT(lat),
      .ENABLE_N_DETECT_STROBE(en_n), .OPEN_OK(ook), .SHORT_TRIP(trip),
      .SHORT_RELEASE(rel), .CHAN_HOT(hot), .GLOBAL_HOT(ghot),
      .SERIAL_OUT(so), .SINK_OUTPUT(sink), .CURRENT_MULTIPLIER_BIT(cm),
      .GAIN_BAND_BIT(band), .GAIN_MANTISSA(mant), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_AWPROT(awp),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(stb), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
      .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_ARADDR(ara), .S_AXI_ARPROT(arp), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rry), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp));

   task automatic chk(input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x) begin
         $display("BAD t=%0t exp=%h got=%h", $time, x, g);
         error_cnt++;
      end
   endtask

   task automatic complete_run;
      if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // read data monitor: oldest note against each accepted answer
   always @(posedge clk) begin
      if (rv === 1'b1 && rry === 1'b1) begin
         e = q.pop_front();
         chk({30'h0, e.r}, {30'h0, rresp});
         chk(e.d, rdata);
      end
   end

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] rr);
      int n;
      q.push_back({d, rr});
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rry <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (arr === 1'b1) arv <= 1'b0;
         n++;
      end while (!(rv === 1'b1) && n < 100);
      if (rv !== 1'b1) error_cnt++;
      rry <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] rr);
      int n;
      @(posedge clk);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= d;
      bry <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wr_rdy === 1'b1) wv <= 1'b0;
         n++;
      end while (!(bv === 1'b1) && n < 100);
      if (bv !== 1'b1) error_cnt++;
      bry <= 1'b0;
      chk({30'h0, rr}, {30'h0, bresp});
   endtask

   function automatic logic [31:0] cfg_out();
      return {24'h0, mant, band, cm};
   endfunction

   initial begin
      #200us;
      error_cnt++;
      complete_run();
   end

   initial begin
      void'($urandom(71518));
      sm = 8'h01 << 3'($urandom());
      hm = 8'h01 << 3'($urandom());
      b = 8'($urandom()) | sm | hm;
      o = 8'($urandom()) | sm | hm;
      awp <= 3'($urandom());
      arp <= 3'($urandom());
      cfg = 8'($urandom());
      r = 8'($urandom());
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rd(lsd_pkg::ADDR_LATCH, 32'h0000_FF00, lsd_pkg::RESP_OKAY);
      rd(lsd_pkg::ADDR_STATUS, 32'h0000_0000, lsd_pkg::RESP_OKAY);
      chk(32'h0000_00FF, cfg_out());
      rd(8'h40, 32'h0000_0000, lsd_pkg::RESP_SLVERR);
      wr(8'h40, 32'h0000_0001, lsd_pkg::RESP_SLVERR);
      wr(lsd_pkg::ADDR_STATUS, 32'h0000_0005, lsd_pkg::RESP_OKAY);
      rd(lsd_pkg::ADDR_STATUS, 32'h0000_0000, lsd_pkg::RESP_OKAY);
      wr(lsd_pkg::ADDR_CTRL, 32'h0000_0001, lsd_pkg::RESP_OKAY);
      rd(lsd_pkg::ADDR_CTRL, 32'h0000_0001, lsd_pkg::RESP_OKAY);
      stb <= 4'($urandom()) & 4'hE;
      wr(lsd_pkg::ADDR_CTRL, 32'h0000_0000, lsd_pkg::RESP_OKAY);
      rd(lsd_pkg::ADDR_CTRL, 32'h0000_0001, lsd_pkg::RESP_OKAY);
      stb <= 4'hF;
      ctl.byte_io(b, 1'b1, 1'b1, s);
      rd(lsd_pkg::ADDR_LATCH, {16'h0, 8'hFF, b}, lsd_pkg::RESP_OKAY);
      ctl.byte_io(8'h00, 1'b1, 1'b0, s);
      chk({24'h0, b[6:0], 1'b0}, {24'h0, s});
      ctl.low(3);
      chk({24'h0, b}, {24'h0, sink});
      ctl.sw_mode(1'b1);
      rd(lsd_pkg::ADDR_STATUS, 32'h0000_0001, lsd_pkg::RESP_OKAY);
      rd(lsd_pkg::ADDR_LATCH, {16'h0, 8'hFF, b}, lsd_pkg::RESP_OKAY);
      ctl.byte_io(cfg, 1'b1, 1'b1, s);
      chk({24'h0, cfg}, cfg_out());
      rd(lsd_pkg::ADDR_LATCH, {16'h0, cfg, b}, lsd_pkg::RESP_OKAY);
      ook <= o;
      ctl.low(34);
      chk({24'h0, b}, {24'h0, sink});
      ctl.byte_io(r, 1'b1, 1'b0, s);
      chk({24'h0, b & o}, {24'h0, s});
      chk(32'h0, {24'h0, sink});
      ctl.byte_io(8'h00, 1'b1, 1'b0, s);
      chk({24'h0, r}, {24'h0, s});
      trip <= sm;
      ctl.low(34);
      trip <= 8'h00;
      ctl.byte_io(8'h00, 1'b1, 1'b0, s);
      chk({24'h0, b & o & ~sm}, {24'h0, s});
      rel <= sm;
      ctl.low(34);
      rel <= 8'h00;
      ctl.byte_io(8'h00, 1'b1, 1'b0, s);
      chk({24'h0, b & o}, {24'h0, s});
      wr(lsd_pkg::ADDR_CTRL, 32'h0000_0000, lsd_pkg::RESP_OKAY);
      rd(lsd_pkg::ADDR_CTRL, 32'h0000_0000, lsd_pkg::RESP_OKAY);
      trip <= sm;
      ctl.low(34);
      trip <= 8'h00;
      ctl.byte_io(8'h00, 1'b1, 1'b0, s);
      chk({24'h0, b & o}, {24'h0, s});
      wr(lsd_pkg::ADDR_CTRL, 32'h0000_0001, lsd_pkg::RESP_OKAY);
      ghot <= 1'b1;
      ctl.low(10);
      chk(32'h0, {24'h0, sink});
      ghot <= 1'b0;
      ctl.low(24);
      chk({24'h0, b}, {24'h0, sink});
      ctl.byte_io(8'h00, 1'b1, 1'b0, s);
      chk(32'h0, {24'h0, s});
      rd(lsd_pkg::ADDR_ERROR, 32'h00FF_0000, lsd_pkg::RESP_OKAY);
      ctl.sw_mode(1'b0);
      rd(lsd_pkg::ADDR_ERROR, 32'h0000_0000, lsd_pkg::RESP_OKAY);
      rd(lsd_pkg::ADDR_STATUS, 32'h0000_0000, lsd_pkg::RESP_OKAY);
      ctl.sw_mode(1'b1);
      ctl.low(3);
      hot <= hm;
      ctl.low(7);
      chk({24'h0, b & ~hm}, {24'h0, sink});
      hot <= 8'h00;
      ctl.low(24);
      ctl.byte_io(8'h00, 1'b1, 1'b0, s);
      chk({24'h0, b & o & ~hm}, {24'h0, s});
      chk({24'h0, cfg}, cfg_out());
      repeat (4) @(posedge clk);
      complete_run();
   end
endmodule // led_sink_mode_and_error_readout_bench
`default_nettype wire
